// ### src/lpm_pkg.sv
// lpm_pkg: shared constants and types of the low power mode controller
package lpm_pkg;
   // ==========================================================
   // mode states
   typedef enum logic [2:0] {
      LPM_RUN     = 3'h0,
      LPM_LIGHT   = 3'h1,
      LPM_DEEP    = 3'h3,
      LPM_OSCWAIT = 3'h2,
      LPM_STANDBY_REQUEST_N    = 3'h6,
      LPM_RESET   = 3'h4
   } lpm_state_t;

   // ==========================================================
   // timing
   localparam int LPM_CLK_HZ       = 10000000;
   localparam int LPM_OSC_SETTLE_US = 1000;
   localparam int LPM_OSC_SETTLE_CYC =
      (LPM_OSC_SETTLE_US * (LPM_CLK_HZ / 1000000) < 1) ? 1 :
      LPM_OSC_SETTLE_US * (LPM_CLK_HZ / 1000000);
   localparam int LPM_CNT_W        = 16;
   localparam int LPM_POR_CYC      = 16;
endpackage : lpm_pkg

// ### src/lpm_delay.sv
// lpm_delay: oscillator settling counter, done when count reaches limit
`timescale 1ns/1ps
module lpm_delay #(
   parameter int W = lpm_pkg::LPM_CNT_W
) (
   input  wire logic         CLOCK,
   input  wire logic         RST,
   input  wire logic         ce,
   input  wire logic         clr,
   input  wire logic [W-1:0] limit,
   output logic              done
);
   logic [W-1:0] cnt_ff;

   if (W < 1) begin : g_bad_w
      $error("counter width must be at least one");
   end

   // ==========================================================
   // counter
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cnt_ff <= {W{1'b0}};
         done   <= 1'b0;
      end else if (ce) begin
         if (clr) begin
            cnt_ff <= {W{1'b0}};
            done   <= 1'b0;
         end else if (cnt_ff >= limit) begin
            done   <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule : lpm_delay

// ### src/lpm_ctrl.sv
// lpm_ctrl: reset and low power mode controller top level
// Contract
// - chip resets on external reset pin low or internal power-on detect
// - light sleep keeps oscillator, gates cpu clock, timer and serial run
// - serial retrigger refused after light sleep entry until it ends
// - registers, ram and pins kept during light sleep
// - light sleep ends on any unmasked irq, reset, or standby
// - accepted wake vectors; masked by cpu flag resumes after opcode
// - peripheral irq masked locally never requests and never wakes
// - deep sleep stops oscillator, cpu and peripherals, keeps state
// - deep sleep ends only by external irq pins, reset or standby
// - deep sleep irq wake vectors or resumes after opcode if masked
// - second external irq masked in misc register cannot wake deep sleep
// - irq wake restarts oscillator then cpu after settling delay
// - reset wake restarts oscillator on low, cpu resumes on high
// - standby low stops all, resets state except ram, pins float
`timescale 1ns/1ps
module lpm_ctrl #(
   parameter int SETTLE_CYC = lpm_pkg::LPM_OSC_SETTLE_CYC
) (
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic CE,
   input  wire logic EXT_RESET_N,
   input  wire logic STANDBY_REQUEST_N,
   input  wire logic LIGHT_SLEEP_OP,
   input  wire logic DEEP_SLEEP_OP,
   input  wire logic CPU_IRQ_MASK,
   input  wire logic EXT_IRQ,
   input  wire logic SECOND_EXTERNAL_IRQ,
   input  wire logic SECOND_EXTERNAL_IRQ_MASK,
   input  wire logic TIMER_IRQ,
   input  wire logic TIMER_IRQ_MASK,
   input  wire logic SERIAL_IRQ,
   input  wire logic SERIAL_IRQ_MASK,
   input  wire logic SERIAL_RETRIGGER,
   output logic      OSC_RUN,
   output logic      CPU_CLK_EN,
   output logic      PERIPH_CLK_EN,
   output logic      CHIP_RESET,
   output logic      PINS_HIGH_Z,
   output logic      WAKE_VECTOR,
   output logic      WAKE_RESUME,
   output logic      SERIAL_RETRIGGER_OK,
   output logic      IRQ_REQUEST
);
   localparam int CW = lpm_pkg::LPM_CNT_W;
   localparam int NSRC = 3;
   localparam logic [CW-1:0] SETTLE_LIMIT = CW'(SETTLE_CYC - 1);

   // ==========================================================
   // elaboration checks
   if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << CW)) begin : g_bad_settle
      $error("SETTLE_CYC out of range");
   end
   if (lpm_pkg::LPM_POR_CYC < 1 ||
       lpm_pkg::LPM_POR_CYC > 31) begin : g_bad_por
      $error("power-on count does not fit its counter");
   end

   lpm_pkg::lpm_state_t state_ff, nxt_state;
   logic [4:0] por_cnt_ff;
   logic       por_ff;
   logic       dly_clr;
   logic       dly_done;
   logic       any_irq;
   logic       ext_irq_any;
   logic [NSRC-1:0] src_req;
   logic [NSRC-1:0] src_mask;
   logic [NSRC-1:0] src_live;

   // ==========================================================
   // power-on detect: held active for a few cycles after RST
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         por_cnt_ff <= 5'h00;
         por_ff     <= 1'b1;
      end else if (CE) begin
         if (por_cnt_ff != 5'(lpm_pkg::LPM_POR_CYC)) begin
            por_cnt_ff <= por_cnt_ff + 5'h01;
         end else begin
            por_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // wake sources
   assign src_req  = {SERIAL_IRQ, TIMER_IRQ, SECOND_EXTERNAL_IRQ};
   assign src_mask = {SERIAL_IRQ_MASK, TIMER_IRQ_MASK,
                      SECOND_EXTERNAL_IRQ_MASK};

   for (genvar gi = 0; gi < NSRC; gi++) begin : g_src
      // locally masked sources never request
      assign src_live[gi] = src_req[gi] & ~src_mask[gi];
   end

   always_comb begin
      // deep sleep hears only the external pins
      ext_irq_any = EXT_IRQ | src_live[0];
      any_irq     = ext_irq_any | src_live[1] | src_live[2];
   end

   // ==========================================================
   // mode state machine
   always_comb begin
      nxt_state = state_ff;
      dly_clr   = 1'b0;
      if (!STANDBY_REQUEST_N) begin
         nxt_state = lpm_pkg::LPM_STANDBY_REQUEST_N;
      end else if (!EXT_RESET_N || por_ff) begin
         nxt_state = lpm_pkg::LPM_RESET;
      end else begin
         case (state_ff)
            lpm_pkg::LPM_RUN: begin
               if (DEEP_SLEEP_OP)
                  nxt_state = lpm_pkg::LPM_DEEP;
               else if (LIGHT_SLEEP_OP)
                  nxt_state = lpm_pkg::LPM_LIGHT;
            end
            lpm_pkg::LPM_LIGHT: begin
               if (any_irq)
                  nxt_state = lpm_pkg::LPM_RUN;
            end
            lpm_pkg::LPM_DEEP: begin
               dly_clr = 1'b1;
               if (ext_irq_any)
                  nxt_state = lpm_pkg::LPM_OSCWAIT;
            end
            lpm_pkg::LPM_OSCWAIT: begin
               if (dly_done)
                  nxt_state = lpm_pkg::LPM_RUN;
            end
            // standby leaves only through reset
            lpm_pkg::LPM_STANDBY_REQUEST_N: nxt_state = lpm_pkg::LPM_STANDBY_REQUEST_N;
            lpm_pkg::LPM_RESET: nxt_state = lpm_pkg::LPM_RUN;
            default: nxt_state = lpm_pkg::LPM_RESET;
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_ff <= lpm_pkg::LPM_RESET;
      end else if (CE) begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // oscillator settling delay
   lpm_delay #(.W(CW)) u_delay (
      .CLOCK (CLOCK),
      .RST   (RST),
      .ce    (CE),
      .clr   (dly_clr),
      .limit (SETTLE_LIMIT),
      .done  (dly_done)
   );

   // ==========================================================
   // clock, reset and pin controls; state kept in sleep
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         OSC_RUN       <= 1'b1;
         CPU_CLK_EN    <= 1'b0;
         PERIPH_CLK_EN <= 1'b0;
         CHIP_RESET    <= 1'b1;
         PINS_HIGH_Z   <= 1'b1;
      end else if (CE) begin
         OSC_RUN       <= (nxt_state != lpm_pkg::LPM_DEEP) &&
                          (nxt_state != lpm_pkg::LPM_STANDBY_REQUEST_N);
         CPU_CLK_EN    <= (nxt_state == lpm_pkg::LPM_RUN);
         PERIPH_CLK_EN <= (nxt_state == lpm_pkg::LPM_RUN) ||
                          (nxt_state == lpm_pkg::LPM_LIGHT);
         CHIP_RESET    <= (nxt_state == lpm_pkg::LPM_RESET) ||
                          (nxt_state == lpm_pkg::LPM_STANDBY_REQUEST_N);
         PINS_HIGH_Z   <= (nxt_state == lpm_pkg::LPM_STANDBY_REQUEST_N);
      end
   end

   // ==========================================================
   // wake result: vector or resume after the sleep opcode
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         WAKE_VECTOR <= 1'b0;
         WAKE_RESUME <= 1'b0;
      end else if (CE) begin
         WAKE_VECTOR <= 1'b0;
         WAKE_RESUME <= 1'b0;
         if (nxt_state == lpm_pkg::LPM_RUN &&
             (state_ff == lpm_pkg::LPM_LIGHT ||
              state_ff == lpm_pkg::LPM_OSCWAIT)) begin
            WAKE_VECTOR <= ~CPU_IRQ_MASK;
            WAKE_RESUME <= CPU_IRQ_MASK;
         end
      end
   end

   // ==========================================================
   // unmasked request to the cpu
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         IRQ_REQUEST <= 1'b0;
      end else if (CE) begin
         IRQ_REQUEST <= any_irq;
      end
   end

   // ==========================================================
   // serial retrigger gate
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         SERIAL_RETRIGGER_OK <= 1'b0;
      end else if (CE) begin
         SERIAL_RETRIGGER_OK <= SERIAL_RETRIGGER &&
                                (nxt_state == lpm_pkg::LPM_RUN);
      end
   end
endmodule : lpm_ctrl

// ### verification/lpm_board.sv
// lpm_board: board-side model of the reset and standby pin drivers
`timescale 1ns/1ps
module lpm_board #(
   parameter int SETTLE = 8
) (
   input  wire logic CLOCK,
   output logic      EXT_RESET_N,
   output logic      STANDBY_REQUEST_N
);
   // ==========
   // pin drive, changed only at falling edges
   initial begin
      STANDBY_REQUEST_N = 1'h1;
      EXT_RESET_N = 1'h0;
      repeat (SETTLE + 2) @(negedge CLOCK);
      EXT_RESET_N = 1'h1;
   end
   task reset_pulse;
      EXT_RESET_N = 1'h0;
      repeat (SETTLE + 2) @(negedge CLOCK);
      EXT_RESET_N = 1'h1;
   endtask : reset_pulse
   task standby(input logic lvl);
      STANDBY_REQUEST_N = lvl;
   endtask : standby
endmodule : lpm_board

// ### verification/lpm_ctrl_properties.sv
// lpm_ctrl_properties: port assertions for lpm_ctrl
`timescale 1ns/1ps
module lpm_ctrl_properties #(
   parameter int SETTLE_CYC = 8
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic EXT_RESET_N,
   input wire logic STANDBY_REQUEST_N,
   input wire logic LIGHT_SLEEP_OP,
   input wire logic DEEP_SLEEP_OP,
   input wire logic CPU_IRQ_MASK,
   input wire logic EXT_IRQ,
   input wire logic SECOND_EXTERNAL_IRQ,
   input wire logic SECOND_EXTERNAL_IRQ_MASK,
   input wire logic OSC_RUN,
   input wire logic CPU_CLK_EN,
   input wire logic PERIPH_CLK_EN,
   input wire logic PINS_HIGH_Z,
   input wire logic CHIP_RESET,
   input wire logic WAKE_VECTOR,
   input wire logic WAKE_RESUME,
   input wire logic SERIAL_RETRIGGER_OK
);
   // ==========
   // helpers and sequences
   localparam int WAIT_LO = SETTLE_CYC - 1;
   wire ok = STANDBY_REQUEST_N && EXT_RESET_N;
   wire run = CPU_CLK_EN && !CHIP_RESET;
   wire dp = !OSC_RUN && !PINS_HIGH_Z;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST || !CE);
   sequence s_light;
      run && LIGHT_SLEEP_OP && !DEEP_SLEEP_OP && ok;
   endsequence
   sequence s_osc_back;
      dp && EXT_IRQ && ok ##1 OSC_RUN;
   endsequence
   // ==========
   // assertions
   AST_STANDBY_WINS: assert property (
      !STANDBY_REQUEST_N |=> PINS_HIGH_Z && !OSC_RUN && !CPU_CLK_EN)
      else $error("standby not forced");
   AST_LIGHT_IN: assert property (
      s_light |=> !CPU_CLK_EN && OSC_RUN && PERIPH_CLK_EN)
      else $error("light sleep entry");
   AST_NO_RETRIG: assert property (
      SERIAL_RETRIGGER_OK |-> CPU_CLK_EN)
      else $error("retrigger while asleep");
   AST_DEEP_IN: assert property (
      run && DEEP_SLEEP_OP && ok |=> dp && !PERIPH_CLK_EN && !CPU_CLK_EN)
      else $error("deep sleep entry");
   AST_DEEP_HOLD: assert property (
      dp && ok && !EXT_IRQ && (!SECOND_EXTERNAL_IRQ ||
      SECOND_EXTERNAL_IRQ_MASK) |=> !OSC_RUN)
      else $error("deep sleep left");
   AST_OSC_WAKE: assert property (
      s_osc_back |-> (!CPU_CLK_EN throughout ##WAIT_LO 1'h1)
      ##[1:3] CPU_CLK_EN)
      else $error("settle delay");
   AST_RST_WAKE: assert property (
      dp && STANDBY_REQUEST_N && !EXT_RESET_N |=> OSC_RUN && CHIP_RESET)
      else $error("reset wake");
   AST_WAKE_KIND: assert property (
      $rose(CPU_CLK_EN) && !$past(CHIP_RESET) |-> WAKE_VECTOR != WAKE_RESUME)
      else $error("wake pulse");
   AST_RESUME: assert property (
      WAKE_VECTOR || WAKE_RESUME |-> WAKE_RESUME == $past(CPU_IRQ_MASK))
      else $error("wake kind");
endmodule : lpm_ctrl_properties
bind lpm_ctrl lpm_ctrl_properties #(.SETTLE_CYC(SETTLE_CYC)) u_props (.*);

// ### verification/test_low_power_mode_controller.sv
// test_low_power_mode_controller: self-checking bench for lpm_ctrl
`timescale 1ns/1ps
module test_low_power_mode_controller;
   // ==========
   // clock, design and board model
   logic CLOCK, RST, CE, LIGHT_SLEEP_OP, DEEP_SLEEP_OP, CPU_IRQ_MASK;
   logic EXT_IRQ, SECOND_EXTERNAL_IRQ, SECOND_EXTERNAL_IRQ_MASK, TIMER_IRQ;
   logic TIMER_IRQ_MASK, SERIAL_IRQ, SERIAL_IRQ_MASK, SERIAL_RETRIGGER;
   logic EXT_RESET_N, STANDBY_REQUEST_N, OSC_RUN, CPU_CLK_EN, PERIPH_CLK_EN;
   logic CHIP_RESET, PINS_HIGH_Z, WAKE_VECTOR, WAKE_RESUME;
   logic SERIAL_RETRIGGER_OK, IRQ_REQUEST;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   lpm_ctrl #(.SETTLE_CYC(8)) dut (.*);
   lpm_board #(.SETTLE(8)) board (.*);
   initial begin
      CLOCK = 1'h0;
      forever #50 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         summarize();
      end
   end
   task summarize;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %b want %b", $time, got, exp);
      end
   endtask : chk
   task step(input int n);
      repeat (n) @(negedge CLOCK);
   endtask : step
   task irqs(input logic [3:0] v, input logic [2:0] mk);
      {EXT_IRQ, SECOND_EXTERNAL_IRQ, TIMER_IRQ, SERIAL_IRQ} = v;
      {SECOND_EXTERNAL_IRQ_MASK, TIMER_IRQ_MASK, SERIAL_IRQ_MASK} = mk;
   endtask : irqs
   task wait_run;
      for (int i = 0; i < 40 && CPU_CLK_EN !== 1'h1; i++) step(1);
   endtask : wait_run
   task restart;
      wait_run();
      chk(CPU_CLK_EN, 1'h1);
      chk(WAKE_VECTOR | WAKE_RESUME, 1'h0);
      irqs(4'h0, 3'h7);
   endtask : restart
   task wake(input logic m);
      wait_run();
      chk(WAKE_VECTOR, ~m);
      chk(WAKE_RESUME, m);
      irqs(4'h0, 3'h7);
   endtask : wake
   // ==========
   // scenarios
   task t_boot;
      restart();
      chk(CHIP_RESET | PINS_HIGH_Z | ~OSC_RUN, 1'h0);
      SERIAL_RETRIGGER = 1'h1;
      step(1);
      chk(SERIAL_RETRIGGER_OK, 1'h1);
      SERIAL_RETRIGGER = 1'h0;
   endtask : t_boot
   task t_freeze;
      CE = 1'h0;
      LIGHT_SLEEP_OP = 1'h1;
      step(2);
      chk(CPU_CLK_EN, 1'h1);
      CE = 1'h1;
      step(1);
      LIGHT_SLEEP_OP = 1'h0;
      chk(CPU_CLK_EN, 1'h0);
      irqs(4'h8, 3'h7);
      step(1);
      wake(1'h0);
   endtask : t_freeze
   task t_light(input logic m, input logic [3:0] v);
      CPU_IRQ_MASK = m;
      LIGHT_SLEEP_OP = 1'h1;
      step(1);
      {LIGHT_SLEEP_OP, SERIAL_RETRIGGER} = 2'h1;
      irqs(4'h7, 3'h7);
      step(3);
      chk(CPU_CLK_EN, 1'h0);
      chk(OSC_RUN & PERIPH_CLK_EN, 1'h1);
      chk(SERIAL_RETRIGGER_OK, 1'h0);
      chk(IRQ_REQUEST, 1'h0);
      SERIAL_RETRIGGER = 1'h0;
      irqs(v, 3'h0);
      step(1);
      chk(CPU_CLK_EN, 1'h1);
      chk(IRQ_REQUEST, 1'h1);
      wake(m);
   endtask : t_light
   task t_deep(input logic m, input logic [3:0] v);
      CPU_IRQ_MASK = m;
      DEEP_SLEEP_OP = 1'h1;
      step(1);
      DEEP_SLEEP_OP = 1'h0;
      irqs(4'h7, 3'h4);
      step(3);
      chk(OSC_RUN | PERIPH_CLK_EN | CPU_CLK_EN, 1'h0);
      irqs(v, 3'h0);
      step(1);
      chk(OSC_RUN & ~CPU_CLK_EN, 1'h1);
      step(7);
      chk(CPU_CLK_EN, 1'h0);
      wake(m);
   endtask : t_deep
   task t_deep_reset;
      DEEP_SLEEP_OP = 1'h1;
      step(1);
      DEEP_SLEEP_OP = 1'h0;
      step(2);
      fork
         board.reset_pulse();
         begin
            step(1);
            chk(OSC_RUN & CHIP_RESET, 1'h1);
         end
      join
      restart();
   endtask : t_deep_reset
   task t_standby;
      LIGHT_SLEEP_OP = 1'h1;
      step(1);
      LIGHT_SLEEP_OP = 1'h0;
      board.standby(1'h0);
      step(2);
      chk(PINS_HIGH_Z & ~OSC_RUN & ~CPU_CLK_EN, 1'h1);
      board.standby(1'h1);
      step(2);
      chk(PINS_HIGH_Z, 1'h1);
      board.reset_pulse();
      restart();
      chk(PINS_HIGH_Z, 1'h0);
   endtask : t_standby
   initial begin
      {RST, CE} = 2'h3;
      {LIGHT_SLEEP_OP, DEEP_SLEEP_OP, CPU_IRQ_MASK, SERIAL_RETRIGGER} = 4'h0;
      irqs(4'h0, 3'h7);
      step(4);
      RST = 1'h0;
      step(1);
      chk(CHIP_RESET, 1'h1);
      t_boot();
      t_freeze();
      for (int i = 0; i < 4; i++) t_light(i[0], 4'h8 >> i);
      for (int i = 0; i < 2; i++) t_deep(i[0], 4'h8 >> i);
      t_deep_reset();
      t_standby();
      summarize();
   end
endmodule : test_low_power_mode_controller
